/* File: adcs_pkg.sv */
// adcs_pkg: register map, field positions, reset values and cycle counts
// of the converter mode sequencer.
// assumes: shared by adcs_conv_unit, adcs_seq_top and the testbench.
package adcs_pkg;

	// register byte offsets on the axi4-lite bus
	localparam logic [7:0] ADDR_CTRL0    = 8'h00; // converter_control_0
	localparam logic [7:0] ADDR_CTRL1    = 8'h04; // converter_control_1
	localparam logic [7:0] ADDR_CTRL2    = 8'h08; // converter_control_2
	localparam logic [7:0] ADDR_CTRL3    = 8'h0c; // converter_control_3
	localparam logic [7:0] ADDR_INTC     = 8'h10; // converter_interrupt_control
	localparam logic [7:0] ADDR_RES_BASE = 8'h20; // result registers 0..7

	// converter_control_0 fields
	localparam int CH_LSB     = 0; // channel_select_bit2..0
	localparam int MODE_LSB   = 3; // operating mode, 2 bits
	localparam int TTYPE_BIT  = 5; // trigger_type_bit
	localparam int START_BIT  = 6; // conversion_start_bit
	// converter_control_1 fields
	localparam int SWEEP_LSB  = 0; // sweep_size_hi/lo
	localparam int EXT_LSB    = 2; // extended_input_sel_hi/lo
	localparam int RES10_BIT  = 4; // 1: 10-bit resolution
	// converter_control_2 fields
	localparam int GROUP_LSB  = 0; // port_group_sel_hi/lo
	localparam int TSRC_LSB   = 2; // trigger_source_hi/lo
	// converter_control_3 / interrupt control fields
	localparam int DMA_BIT    = 0; // dma_operating_mode_bit
	localparam int IRQF_BIT   = 0; // interrupt_request_flag
	localparam int BUSY_BIT   = 1; // sequencer active, read only

	localparam logic [7:0] CTRL_RST = 8'h00;

	// trigger sources and extended input codes
	localparam logic [1:0] TSRC_EXT = 2'h0;
	localparam logic [1:0] TSRC_TB2 = 2'h1;
	localparam logic [1:0] TSRC_TA0 = 2'h2;
	localparam logic [1:0] EXT_IN0  = 2'h1;
	localparam logic [1:0] EXT_IN1  = 2'h2;

	// conversion length in converter clocks, sample time included
	localparam int CONV8_CYC  = 28;
	localparam int CONV10_CYC = 33;
	localparam int SAMPLE_CYC = 3;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		MODE_ONESHOT,
		MODE_REPEAT,
		MODE_SSWEEP,
		MODE_RSWEEP0
	} adcs_mode_e;

endpackage

/* File: adcs_conv_if.sv */
// adcs_conv_if: handshake between the sequencer and the conversion timer.
// assumes: one clock; start and abort are single-cycle requests.
`timescale 1ns/100ps
interface adcs_conv_if;
	logic       start;
	logic       abort;
	logic       res10;
	logic       busy;
	logic       done;
	logic [9:0] data;

	modport seq  (output start, abort, res10, input busy, done, data);
	modport unit (input start, abort, res10, output busy, done, data);
endinterface

/* File: adcs_conv_unit.sv */
// adcs_conv_unit: times one conversion and captures the converter result.
// assumes: adc_data_i comes from logic on clk_i and is settled at the end.
`timescale 1ns/100ps
module adcs_conv_unit #(
	parameter int CNT_W = 6
) (
	input  wire logic       clk_i,      // converter clock
	input  wire logic       rst_i,      // sync reset, active high
	input  wire logic       ce_i,       // clock enable
	adcs_conv_if.unit       cv,         // sequencer side
	input  wire logic [9:0] adc_data_i, // raw converter code
	output logic            sample_o    // sample-and-hold window
);
	if (adcs_pkg::CONV10_CYC >= (1 << CNT_W)) begin : g_bad_cnt
		$error("CNT_W too small for conversion length");
	end

	localparam logic [CNT_W-1:0] LAST8  = CNT_W'(adcs_pkg::CONV8_CYC - 1);
	localparam logic [CNT_W-1:0] LAST10 = CNT_W'(adcs_pkg::CONV10_CYC - 1);
	localparam logic [CNT_W-1:0] SMP    = CNT_W'(adcs_pkg::SAMPLE_CYC);

	logic [CNT_W-1:0] cnt_q;
	logic             res10_q;
	logic             busy_q;
	logic             done_q;
	logic [9:0]       data_q;
	logic             last;

	assign last     = cnt_q == (res10_q ? LAST10 : LAST8);
	assign sample_o = busy_q && (cnt_q < SMP);
	assign cv.busy  = busy_q;
	assign cv.done  = done_q;
	assign cv.data  = data_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_q  <= 1'b0;
			cnt_q   <= '0;
			res10_q <= 1'b0;
		end else if (ce_i) begin
			if (cv.abort) begin
				busy_q <= 1'b0;
			end else if (cv.start && !busy_q) begin
				busy_q  <= 1'b1;
				cnt_q   <= '0;
				res10_q <= cv.res10;
			end else if (busy_q) begin
				cnt_q <= cnt_q + 1'b1;
				if (last) begin
					busy_q <= 1'b0; // 28 or 33 clocks per channel
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			done_q <= 1'b0;
			data_q <= 10'h000;
		end else if (ce_i) begin
			done_q <= busy_q && last && !cv.abort;
			if (busy_q && last) begin
				// 8-bit results sit right-aligned
				data_q <= res10_q ? adc_data_i : {2'h0, adc_data_i[9:2]};
			end
		end
	end

	// conversion length helper, counts every enabled busy clock since start
	logic [CNT_W-1:0] len_q;
	always_ff @(posedge clk_i) begin
		if (rst_i || (ce_i && cv.start && !busy_q)) begin
			len_q <= '0;
		end else if (ce_i && busy_q) begin
			len_q <= len_q + 1'b1;
		end
	end

	chk_conv_length: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(done_q) |-> len_q == (res10_q ? LAST10 : LAST8) + 1'b1)
		else $error("conversion length wrong");
endmodule

/* File: adcs_seq_top.sv */
// adcs_seq_top: mode sequencer of the converter with axi4-lite registers.
// assumes: one clock; timer trigger inputs are one-cycle pulses on clk_i,
// the external trigger pin is asynchronous.
//
// Local design decisions: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps

// Functional notes
// - one-shot converts selected channel once, stops
// - trigger type 0: start bit write starts
// - trigger type 1: start on selected source
// - source 00: external pin falling edge starts
// - source 01: filtered timer B2 request starts
// - source 10: timer A0 request starts
// - software-trigger one-shot/single sweep clears start
// - writing start 0 always stops conversion
// - repeat mode reconverts channel until stopped
// - repeat sweep 0 restarts sweep until stopped
// - single sweep converts group once per start
// - one-shot raises interrupt at completion
// - repeat modes interrupt per conversion only with DMA
// - single sweep: per-sweep interrupt, per-conversion with DMA
// - single modes pick channel, extended input, group
// - sweeps cover 2/4/6/8 channels from 0
// - no DMA: result to matching channel register
// - DMA mode: every result to first register
// - conversion takes 28 or 33 converter clocks
module adcs_seq_top (
	input  wire logic        clk_i,           // converter clock, 20 MHz
	input  wire logic        rst_i,           // sync reset, active high
	input  wire logic        ce_i,            // clock enable, freezes all state
	input  wire logic        s_axi_awvalid,   // write address valid
	output logic             s_axi_awready,   // write address ready
	input  wire logic [7:0]  s_axi_awaddr,    // write byte address
	input  wire logic        s_axi_wvalid,    // write data valid
	output logic             s_axi_wready,    // write data ready
	input  wire logic [31:0] s_axi_wdata,     // write data
	input  wire logic [3:0]  s_axi_wstrb,     // byte enables
	output logic             s_axi_bvalid,    // write response valid
	input  wire logic        s_axi_bready,    // write response ready
	output logic [1:0]       s_axi_bresp,     // write response
	input  wire logic        s_axi_arvalid,   // read address valid
	output logic             s_axi_arready,   // read address ready
	input  wire logic [7:0]  s_axi_araddr,    // read byte address
	output logic             s_axi_rvalid,    // read data valid
	input  wire logic        s_axi_rready,    // read data ready
	output logic [31:0]      s_axi_rdata,     // read data
	output logic [1:0]       s_axi_rresp,     // read response
	input  wire logic        ext_trig_n_i,    // external_trigger_pin, async
	input  wire logic        tmr_b2_req_i,    // filtered timer B2 request pulse
	input  wire logic        tmr_a0_req_i,    // timer A0 request pulse
	input  wire logic [9:0]  adc_data_i,      // raw converter code
	output logic             sample_o,        // sample-and-hold window
	output logic [1:0]       ain_group_o,     // selected port group
	output logic [2:0]       ain_chan_o,      // selected channel in group
	output logic [1:0]       ain_ext_o,       // 01/10: extended input 0/1
	output logic             conv_irq_o,      // converter interrupt pulse
	output logic             dma_req_o        // first result register loaded
);
	typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_LAUNCH, ST_WAIT} adcs_state_e;

	adcs_conv_if cv ();

	adcs_conv_unit #(.CNT_W(6)) u_conv (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.ce_i       (ce_i),
		.cv         (cv),
		.adc_data_i (adc_data_i),
		.sample_o   (sample_o)
	);

	localparam logic [5:0] ADDR_IDX_LAST = adcs_pkg::ADDR_INTC[7:2];
	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a[7:2] <= ADDR_IDX_LAST) || (a[7:5] == 3'h1);
	endfunction

	logic [7:0]  ctrl0_q, ctrl1_q, ctrl2_q, ctrl3_q;
	logic        irqf_q;
	logic [9:0]  res_q [8];
	adcs_state_e st_q;
	logic [2:0]  idx_q;
	logic [2:0]  chan_q;

	// field views
	adcs_pkg::adcs_mode_e mode;
	logic       ttype, dma, res10;
	logic [1:0] tsrc, ext_sel;
	logic [3:0] sweep_n;
	assign mode    = adcs_pkg::adcs_mode_e'(ctrl0_q[adcs_pkg::MODE_LSB +: 2]);
	assign ttype   = ctrl0_q[adcs_pkg::TTYPE_BIT];
	assign res10   = ctrl1_q[adcs_pkg::RES10_BIT];
	assign ext_sel = ctrl1_q[adcs_pkg::EXT_LSB +: 2];
	assign tsrc    = ctrl2_q[adcs_pkg::TSRC_LSB +: 2];
	assign dma     = ctrl3_q[adcs_pkg::DMA_BIT];
	// 00/01/10/11 select 2/4/6/8 channels
	assign sweep_n = {1'b0, ctrl1_q[adcs_pkg::SWEEP_LSB +: 2], 1'b0} + 4'h2;

	// axi4-lite write: address and data are held until both are in
	logic        aw_full_q, w_full_q, bvalid_q;
	logic [7:0]  aw_q;
	logic [31:0] wd_q;
	logic [3:0]  ws_q;
	logic        wr_en;
	assign s_axi_awready = ce_i && !aw_full_q;
	assign s_axi_wready  = ce_i && !w_full_q;
	assign s_axi_bvalid  = bvalid_q;
	assign wr_en = ce_i && aw_full_q && w_full_q && !bvalid_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			aw_full_q <= 1'b0;
			w_full_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			aw_q      <= 8'h00;
			wd_q      <= 32'h0000_0000;
			ws_q      <= 4'h0;
			s_axi_bresp <= adcs_pkg::RESP_OKAY;
		end else if (ce_i) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_q <= 1'b1;
				aw_q      <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_q <= 1'b1;
				wd_q     <= s_axi_wdata;
				ws_q     <= s_axi_wstrb;
			end
			if (wr_en) begin
				bvalid_q <= 1'b1;
				s_axi_bresp <= addr_ok(aw_q) ? adcs_pkg::RESP_OKAY
				                             : adcs_pkg::RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q  <= 1'b0;
				aw_full_q <= 1'b0;
				w_full_q  <= 1'b0;
			end
		end
	end

	// register write strobes, low byte lane only carries settings
	logic wr_c0, start_set, stop_req;
	function automatic logic wr_hit(input logic [7:0] off);
		wr_hit = wr_en && ws_q[0] && (aw_q[7:2] == off[7:2]);
	endfunction
	assign wr_c0     = wr_hit(adcs_pkg::ADDR_CTRL0);
	assign start_set = wr_c0 && wd_q[adcs_pkg::START_BIT];
	assign stop_req  = wr_c0 && !wd_q[adcs_pkg::START_BIT];

	// sequencer events
	logic done_ev, last_ch, trig_evt, fall_seen;
	logic ext_s1_q, ext_s2_q, ext_s3_q;
	assign done_ev = ce_i && cv.done && st_q == ST_WAIT;
	assign last_ch = ({1'b0, idx_q} == sweep_n - 4'h1);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_s1_q <= 1'b1;
			ext_s2_q <= 1'b1;
			ext_s3_q <= 1'b1;
		end else if (ce_i) begin
			ext_s1_q <= ext_trig_n_i;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
		end
	end
	assign fall_seen = ext_s3_q && !ext_s2_q;

	always_comb begin
		case (tsrc)
			adcs_pkg::TSRC_EXT: trig_evt = fall_seen;
			adcs_pkg::TSRC_TB2: trig_evt = tmr_b2_req_i;
			adcs_pkg::TSRC_TA0: trig_evt = tmr_a0_req_i;
			default:            trig_evt = 1'b0;
		endcase
	end

	// one-shot and single sweep end the run here
	logic run_end, hw_clear;
	assign run_end  = mode == adcs_pkg::MODE_ONESHOT ||
	                  (mode == adcs_pkg::MODE_SSWEEP && last_ch);
	assign hw_clear = done_ev && run_end && !ttype;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q  <= ST_IDLE;
			idx_q <= 3'h0;
		end else if (ce_i) begin
			if (stop_req) begin
				st_q <= ST_IDLE;
			end else begin
				case (st_q)
					ST_IDLE: if (start_set) begin
						st_q  <= ttype ? ST_ARM : ST_LAUNCH;
						idx_q <= 3'h0;
					end
					ST_ARM: if (trig_evt) begin
						// events are only looked at once armed
						st_q  <= ST_LAUNCH;
						idx_q <= 3'h0;
					end
					ST_LAUNCH: st_q <= ST_WAIT;
					ST_WAIT: if (cv.done) begin
						if (run_end) begin
							// hardware trigger stays armed for a retrigger
							st_q <= ttype ? ST_ARM : ST_IDLE;
						end else begin
							st_q <= ST_LAUNCH;
						end
						if (mode == adcs_pkg::MODE_SSWEEP ||
						    mode == adcs_pkg::MODE_RSWEEP0) begin
							idx_q <= last_ch ? 3'h0 : idx_q + 3'h1;
						end
					end
					default: st_q <= ST_IDLE;
				endcase
			end
		end
	end

	assign cv.start = ce_i && st_q == ST_LAUNCH && !stop_req;
	assign cv.abort = stop_req;
	assign cv.res10 = res10;

	// channel routing, latched at launch so register writes mid-run do no harm
	logic single;
	assign single = mode == adcs_pkg::MODE_ONESHOT || mode == adcs_pkg::MODE_REPEAT;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			chan_q      <= 3'h0;
			ain_chan_o  <= 3'h0;
			ain_group_o <= 2'h0;
			ain_ext_o   <= 2'h0;
		end else if (ce_i && st_q == ST_LAUNCH) begin
			chan_q      <= single ? ctrl0_q[adcs_pkg::CH_LSB +: 3] : idx_q;
			ain_chan_o  <= single ? ctrl0_q[adcs_pkg::CH_LSB +: 3] : idx_q;
			ain_group_o <= ctrl2_q[adcs_pkg::GROUP_LSB +: 2];
			ain_ext_o   <= (single && (ext_sel == adcs_pkg::EXT_IN0 ||
			                ext_sel == adcs_pkg::EXT_IN1)) ? ext_sel : 2'h0;
		end
	end

	// results
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < 8; i++) begin
				res_q[i] <= 10'h000;
			end
			dma_req_o <= 1'b0;
		end else if (ce_i) begin
			dma_req_o <= done_ev && dma;
			if (done_ev) begin
				if (dma) begin
					res_q[0] <= cv.data;
				end else begin
					res_q[chan_q] <= cv.data;
				end
			end
		end
	end

	// interrupt decision per mode
	logic irq_ev;
	always_comb begin
		case (mode)
			adcs_pkg::MODE_ONESHOT: irq_ev = done_ev;
			adcs_pkg::MODE_SSWEEP:  irq_ev = done_ev && (dma || last_ch);
			default:                irq_ev = done_ev && dma;
		endcase
	end

	// control registers; hardware clear of the start bit loses to a write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl0_q <= adcs_pkg::CTRL_RST;
			ctrl1_q <= adcs_pkg::CTRL_RST;
			ctrl2_q <= adcs_pkg::CTRL_RST;
			ctrl3_q <= adcs_pkg::CTRL_RST;
		end else if (ce_i) begin
			if (wr_c0) begin
				ctrl0_q <= wd_q[7:0];
			end else if (hw_clear) begin
				ctrl0_q[adcs_pkg::START_BIT] <= 1'b0;
			end
			if (wr_hit(adcs_pkg::ADDR_CTRL1)) ctrl1_q <= wd_q[7:0];
			if (wr_hit(adcs_pkg::ADDR_CTRL2)) ctrl2_q <= wd_q[7:0];
			if (wr_hit(adcs_pkg::ADDR_CTRL3)) ctrl3_q <= wd_q[7:0];
		end
	end

	// flag: a new request wins over a software clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irqf_q     <= 1'b0;
			conv_irq_o <= 1'b0;
		end else if (ce_i) begin
			conv_irq_o <= irq_ev;
			if (irq_ev) begin
				irqf_q <= 1'b1;
			end else if (wr_hit(adcs_pkg::ADDR_INTC) && !wd_q[adcs_pkg::IRQF_BIT]) begin
				irqf_q <= 1'b0;
			end
		end
	end

	// axi4-lite read, one cycle after the address is taken
	logic rvalid_q;
	logic [31:0] rd_word;
	assign s_axi_arready = ce_i && !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	always_comb begin
		rd_word = 32'h0000_0000;
		if (s_axi_araddr[7:5] == 3'h1) begin
			rd_word = {22'h0, res_q[s_axi_araddr[4:2]]};
		end else begin
			case ({s_axi_araddr[7:2], 2'h0})
				adcs_pkg::ADDR_CTRL0: rd_word = {24'h0, ctrl0_q};
				adcs_pkg::ADDR_CTRL1: rd_word = {24'h0, ctrl1_q};
				adcs_pkg::ADDR_CTRL2: rd_word = {24'h0, ctrl2_q};
				adcs_pkg::ADDR_CTRL3: rd_word = {24'h0, ctrl3_q};
				adcs_pkg::ADDR_INTC:  rd_word = {30'h0, st_q != ST_IDLE, irqf_q};
				default:              rd_word = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rvalid_q    <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= adcs_pkg::RESP_OKAY;
		end else if (ce_i) begin
			if (s_axi_arvalid && s_axi_arready) begin
				rvalid_q    <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= addr_ok(s_axi_araddr) ? adcs_pkg::RESP_OKAY
				                                     : adcs_pkg::RESP_SLVERR;
			end else if (s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_sw_start: assert property (
		st_q == ST_IDLE && start_set && !ttype |=> st_q == ST_LAUNCH ##1 cv.busy)
		else $error("software start did not launch");
	chk_armed_wait: assert property (
		st_q == ST_ARM && !(ce_i && trig_evt) && !stop_req |=> st_q == ST_ARM)
		else $error("armed state left without trigger");
	chk_ext_fall: assert property (
		st_q == ST_ARM && ce_i && tsrc == adcs_pkg::TSRC_EXT && fall_seen &&
		!stop_req |=> st_q == ST_LAUNCH)
		else $error("external falling edge not taken");
	chk_ta0_start: assert property (
		st_q == ST_ARM && ce_i && tsrc == adcs_pkg::TSRC_TA0 && tmr_a0_req_i &&
		!stop_req |=> st_q == ST_LAUNCH)
		else $error("timer A0 request not taken");
	chk_stop_write: assert property (
		stop_req |=> st_q == ST_IDLE && !cv.busy)
		else $error("stop write did not stop");
	chk_oneshot_end: assert property (
		done_ev && mode == adcs_pkg::MODE_ONESHOT && !ttype && !wr_c0 |=>
		st_q == ST_IDLE && !ctrl0_q[adcs_pkg::START_BIT])
		else $error("one-shot did not end and clear start");
	chk_oneshot_irq: assert property (
		done_ev && mode == adcs_pkg::MODE_ONESHOT |=> conv_irq_o && irqf_q)
		else $error("one-shot gave no interrupt");
	chk_repeat_quiet: assert property (
		done_ev && mode == adcs_pkg::MODE_REPEAT && !dma |=> !conv_irq_o)
		else $error("repeat without dma interrupted");
	chk_result_store: assert property (
		done_ev && !dma |=> res_q[$past(chan_q)] == $past(cv.data))
		else $error("result not in channel register");
	chk_dma_store: assert property (
		done_ev && dma |=> res_q[0] == $past(cv.data) && dma_req_o)
		else $error("dma result not in first register");
	chk_repeat_relaunch: assert property (
		done_ev && mode == adcs_pkg::MODE_REPEAT && !stop_req |=> st_q == ST_LAUNCH)
		else $error("repeat mode did not relaunch");

	cov_oneshot_done: cover property (done_ev && mode == adcs_pkg::MODE_ONESHOT);
	cov_sweep_wrap: cover property (done_ev && mode == adcs_pkg::MODE_RSWEEP0 && last_ch);
	cov_tb2_start: cover property (st_q == ST_ARM && ce_i && tsrc == adcs_pkg::TSRC_TB2
		&& tmr_b2_req_i);
	cov_dma_irq: cover property (irq_ev && dma);
endmodule

/* File: adcs_far_model.sv */
// adcs_far_model: analog source and trigger sources seen by the sequencer.
// assumes: one clock; the bench fires triggers through the fire task.
`timescale 1ns/100ps
module adcs_far_model (
	input  wire logic       clk_i,   // converter clock
	input  wire logic [1:0] group_i, // selected group
	input  wire logic [2:0] chan_i,  // selected channel
	input  wire logic [1:0] ext_i,   // extended select
	input  wire logic [2:0] salt_i,  // low code bits
	output logic [9:0]      code_o,  // converter code
	output logic            pin_n_o, // external trigger pin
	output logic            tb2_o,   // filtered timer request
	output logic            ta0_o    // timer request
);
	// the code names its own input, so a misrouted result cannot pass
	assign code_o = {group_i, chan_i, ext_i, salt_i};
	initial begin
		pin_n_o = 1'b1;
		tb2_o = 1'b0;
		ta0_o = 1'b0;
	end
	// pin low for several cycles so the synchroniser surely sees the fall
	task automatic fire(input logic [1:0] src);
		@(posedge clk_i);
		if (src == 2'h0) pin_n_o <= 1'b0;
		else if (src == 2'h1) tb2_o <= 1'b1;
		else ta0_o <= 1'b1;
		@(posedge clk_i);
		tb2_o <= 1'b0;
		ta0_o <= 1'b0;
		repeat (3) @(posedge clk_i);
		pin_n_o <= 1'b1;
	endtask
endmodule

/* File: testbench.sv */
// testbench: drives the sequencer over axi4-lite, checks modes and results.
// assumes: adcs_pkg compiled first; ce_i held high.
`timescale 1ns/100ps
module testbench;
	logic             clk_i = 1'b0;
	logic             rst_i = 1'b1;
	logic             awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
	logic [7:0]       awa = 8'h00, ara = 8'h00;
	logic [31:0]      wd = 32'h0;
	logic [2:0]       salt = 3'h0;
	wire logic        awr, wrdy, bv, arr, rv, smp, irq, dreq, pin_n, tb2, ta0;
	wire logic [1:0]  bresp, rresp, grp, ext;
	wire logic [2:0]  chan;
	wire logic [9:0]  code;
	wire logic [31:0] rdata;
	logic [31:0]      rd;
	logic [1:0]       resp;
	int               miscompares = 0, n_checks = 0, cyc = 0;

	always #25 clk_i = ~clk_i;

	adcs_seq_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
		.s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
		.s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_bresp(bresp),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
		.s_axi_rvalid(rv), .s_axi_rready(rrdy), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.ext_trig_n_i(pin_n), .tmr_b2_req_i(tb2), .tmr_a0_req_i(ta0), .adc_data_i(code),
		.sample_o(smp), .ain_group_o(grp), .ain_chan_o(chan), .ain_ext_o(ext),
		.conv_irq_o(irq), .dma_req_o(dreq));
	adcs_far_model far_u (.clk_i(clk_i), .group_i(grp), .chan_i(chan), .ext_i(ext),
		.salt_i(salt), .code_o(code), .pin_n_o(pin_n), .tb2_o(tb2), .ta0_o(ta0));

	task automatic summarize;
		$display("checks %0d, mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// 8-bit results keep the upper code bits, right aligned
	function automatic logic [31:0] expc(input logic [1:0] g, input logic [2:0] c,
		input logic r10);
		logic [9:0] v;
		v = {g, c, 2'h0, salt};
		return r10 ? {22'h0, v} : {24'h0, v[9:2]};
	endfunction

	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		awa <= a;
		wd <= {24'h0, d};
		awv <= 1'b1;
		wv <= 1'b1;
		brdy <= 1'b1;
		do begin
			@(posedge clk_i);
			if (awr) awv <= 1'b0;
			if (wrdy) wv <= 1'b0;
		end while (bv !== 1'b1);
		resp = bresp;
		brdy <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic rreg(input logic [7:0] a);
		ara <= a;
		arv <= 1'b1;
		rrdy <= 1'b1;
		do begin
			@(posedge clk_i);
			if (arr) arv <= 1'b0;
		end while (rv !== 1'b1);
		rd = rdata;
		resp = rresp;
		rrdy <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic cnt(input int len, output int ni, output int nd);
		ni = 0;
		nd = 0;
		repeat (len) begin
			@(posedge clk_i);
			ni += (irq === 1'b1);
			nd += (dreq === 1'b1);
		end
	endtask

	task automatic wirq(output int n);
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (irq !== 1'b1 && n < 200);
	endtask

	always @(posedge clk_i) begin
		cyc++;
		if (cyc > 10000) begin
			miscompares++;
			summarize();
		end
	end

	initial begin
		int n, ni, nd, sz;
		logic [2:0] ch;
		logic [1:0] g;
		void'($urandom(68));
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rreg(8'h14);
		check(32'(resp), 32'(adcs_pkg::RESP_SLVERR));
		// one-shot, software start, 8-bit then 10-bit
		for (int r = 0; r < 2; r++) begin
			ch = 3'($urandom);
			g = 2'($urandom_range(2));
			salt <= 3'($urandom);
			wreg(adcs_pkg::ADDR_CTRL1, 8'(r << 4));
			wreg(adcs_pkg::ADDR_CTRL2, {6'h0, g});
			wreg(adcs_pkg::ADDR_CTRL0, 8'h40 | {5'h0, ch});
			do @(posedge clk_i); while (smp !== 1'b1);
			wirq(n);
			check(32'(n), 32'(r ? adcs_pkg::CONV10_CYC : adcs_pkg::CONV8_CYC));
			rreg(adcs_pkg::ADDR_RES_BASE + 8'(4 * ch));
			check(rd, expc(g, ch, r[0]));
			rreg(adcs_pkg::ADDR_CTRL0);
			check(rd, {29'h0, ch});
			rreg(adcs_pkg::ADDR_INTC);
			check(rd, 32'h1);
			cnt(100, ni, nd);
			check(32'(ni), 32'h0);
			wreg(adcs_pkg::ADDR_INTC, 8'h0);
		end
		// repeat and repeat sweep 0, without and with dma mode
		wreg(adcs_pkg::ADDR_CTRL1, 8'h01);
		for (int k = 0; k < 4; k++) begin
			wreg(adcs_pkg::ADDR_CTRL3, 8'(k & 1));
			wreg(adcs_pkg::ADDR_CTRL0, (k < 2) ? 8'h48 : 8'h58);
			cnt(330, ni, nd);
			check(32'((k & 1) ? ni >= 8 : ni == 0), 32'h1);
			check(32'(nd), 32'(ni));
			wreg(adcs_pkg::ADDR_CTRL0, 8'h0);
			cnt(100, ni, nd);
			check(32'(ni + nd), 32'h0);
		end
		// single sweep of a random size and group
		for (int d = 0; d < 2; d++) begin
			sz = 2 * ($urandom_range(3) + 1);
			g = 2'($urandom_range(2));
			wreg(adcs_pkg::ADDR_CTRL3, 8'(d));
			wreg(adcs_pkg::ADDR_CTRL1, 8'(sz / 2 - 1));
			wreg(adcs_pkg::ADDR_CTRL2, {6'h0, g});
			wreg(adcs_pkg::ADDR_CTRL0, 8'h50);
			cnt(35 * sz, ni, nd);
			check(32'(ni), 32'(d ? sz : 1));
			check(32'(nd), 32'(d ? sz : 0));
			for (int j = 0; j < (d ? 1 : sz); j++) begin
				rreg(adcs_pkg::ADDR_RES_BASE + 8'(4 * j));
				check(rd, expc(g, 3'(d ? sz - 1 : j), 1'b0));
			end
			rreg(adcs_pkg::ADDR_CTRL0);
			check(rd, 32'h10);
			// first register is read by software here, no dma controller attached
			wreg(adcs_pkg::ADDR_INTC, 8'h0);
			check(32'(resp), 32'(adcs_pkg::RESP_OKAY));
		end
		// each trigger source: early event ignored, armed event starts
		wreg(adcs_pkg::ADDR_CTRL3, 8'h0);
		for (int s = 0; s < 3; s++) begin
			wreg(adcs_pkg::ADDR_CTRL2, 8'(s << 2));
			wreg(adcs_pkg::ADDR_CTRL0, 8'h20);
			far_u.fire(2'(s));
			wreg(adcs_pkg::ADDR_CTRL0, 8'h60);
			cnt(60, ni, nd);
			check(32'(ni), 32'h0);
			far_u.fire(2'(s));
			wirq(n);
			check(32'(n < 200), 32'h1);
			wreg(adcs_pkg::ADDR_CTRL0, 8'h0);
		end
		summarize();
	end
endmodule
